/* File: dv/cpu_clock_divider_wakeup_tb_top.sv */
// Self-checking bench for the CPU clock control block.
`timescale 1ns/1ps
module cpu_clock_divider_wakeup_tb_top;
   import clock_control_pkg::*;
   localparam int FIXED = 20;
   logic           sys_clk = 1'b0;
   logic           rst_n = 1'b0;
   logic           por_n = 1'b0;
   logic [7:0]     sfr_addr = 8'h00;
   logic           sfr_write = 1'b0;
   logic           sfr_read = 1'b0;
   logic [7:0]     sfr_wdata = 8'h00;
   logic [7:0]     sfr_rdata;
   osc_source_type osc_source_select = SRC_RC;
   logic           wakeup_request = 1'b0;
   logic [1:0]     xcnt = 2'h0;
   wire            crystal_input_pin = xcnt[1];
   logic           xo_out;
   logic           xo_oe_n;
   logic           cpu_clock_tick;
   logic           cpu_clock_running;
   logic           low_power_clock_select;
   int             since_tick = 0;
   int             n_mismatch = 0;
   int             total_checks = 0;

   always #5 sys_clk = ~sys_clk;

   // External clock has a rising edge every four system clocks.
   always @(negedge sys_clk) begin
      xcnt <= xcnt + 2'h1;
      since_tick <= (cpu_clock_tick === 1'b1) ? 1 : since_tick + 1;
   end

   cpu_clock_control #(.HOLD_FIXED_COUNT(FIXED)) DUT (
      .sys_clk                 (sys_clk),
      .rst_n                   (rst_n),
      .por_n                   (por_n),
      .sfr_addr                (sfr_addr),
      .sfr_write               (sfr_write),
      .sfr_read                (sfr_read),
      .sfr_wdata               (sfr_wdata),
      .sfr_rdata               (sfr_rdata),
      .osc_source_select       (osc_source_select),
      .wakeup_request          (wakeup_request),
      .crystal_input_pin       (crystal_input_pin),
      .crystal_output_pin_out  (xo_out),
      .crystal_output_pin_oe_n (xo_oe_n),
      .cpu_clock_tick          (cpu_clock_tick),
      .cpu_clock_running       (cpu_clock_running),
      .low_power_clock_select  (low_power_clock_select)
   );

   ////////////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task automatic give_up();
      n_mismatch++;
      $display("unexpected timeout at %0t: expected %h, got %h", $time, 1'b1, 1'b0);
      close_out();
   endtask

   task automatic chk_byte(input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected byte at %0t: expected %h, got %h", $time, exp, got);
      end
   endtask

   task automatic chk_bit(input logic exp, input logic got);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected bit at %0t: expected %h, got %h", $time, exp, got);
      end
   endtask

   task automatic chk_range(input int lo, input int hi, input int got);
      total_checks++;
      if (got < lo || got > hi) begin
         n_mismatch++;
         $display("unexpected count at %0t: expected %h..%h, got %h", $time, lo, hi, got);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic sfr_wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge sys_clk);
      sfr_addr = a;
      sfr_wdata = v;
      sfr_write = 1'b1;
      @(negedge sys_clk);
      sfr_write = 1'b0;
   endtask

   task automatic sfr_rd(input logic [7:0] a, output logic [7:0] v);
      @(negedge sys_clk);
      sfr_addr = a;
      sfr_read = 1'b1;
      @(negedge sys_clk);
      sfr_read = 1'b0;
      @(negedge sys_clk);
      v = sfr_rdata;
   endtask

   task automatic do_reset(input logic por);
      @(negedge sys_clk);
      rst_n = 1'b0;
      por_n = ~por;
      repeat (20) @(negedge sys_clk);
      rst_n = 1'b1;
      por_n = 1'b1;
   endtask

   task automatic wait_run(output int c);
      c = 0;
      while (cpu_clock_running !== 1'b1) begin
         @(negedge sys_clk);
         c++;
         if (c > 20000) give_up();
      end
   endtask

   // Returns the cycles between the next CPU tick and the one before it.
   task automatic tick_gap(output int g);
      int w;
      w = 0;
      do begin
         @(negedge sys_clk);
         w++;
         if (w > 3000) give_up();
      end while (cpu_clock_tick !== 1'b1);
      g = since_tick;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic s_hold(input osc_source_type s, input logic por, input int t, input int p);
      int c;
      osc_source_select = s;
      do_reset(por);
      wait_run(c);
      chk_range((t - 1) * p + FIXED, (t + 1) * p + FIXED + 8, c);
   endtask

   task automatic s_reset_values();
      logic [7:0] v;
      sfr_rd(TRIM_ADDR, v);
      chk_byte({2'b00, TRIM_FACTORY}, v);
      sfr_rd(AUX_ONE_ADDR, v);
      chk_byte(8'h00, v);
      sfr_rd(8'h00, v);
      chk_byte(8'h00, v);
      chk_bit(1'b1, xo_oe_n);
   endtask

   task automatic s_register_access();
      logic [7:0] v;
      sfr_wr(TRIM_ADDR, 8'hff);
      sfr_rd(TRIM_ADDR, v);
      chk_byte(8'h7f, v);
      sfr_wr(TRIM_ADDR, 8'hbf);
      sfr_wr(AUX_ONE_ADDR, 8'h80);
      sfr_rd(AUX_ONE_ADDR, v);
      chk_byte(8'h80, v);
      chk_bit(1'b1, low_power_clock_select);
      do_reset(1'b0);
      sfr_rd(TRIM_ADDR, v);
      chk_byte(8'h3f, v);
      chk_bit(1'b0, low_power_clock_select);
   endtask

   task automatic s_divider();
      int g;
      tick_gap(g);
      tick_gap(g);
      chk_range(4, 4, g);
      sfr_wr(DIVIDER_ADDR, 8'h03);
      tick_gap(g);
      tick_gap(g);
      chk_range(24, 24, g);
      sfr_wr(DIVIDER_ADDR, 8'hff);
      tick_gap(g);
      tick_gap(g);
      chk_range(2040, 2040, g);
      repeat (100) @(negedge sys_clk);
      sfr_wr(DIVIDER_ADDR, 8'h02);
      tick_gap(g);
      chk_range(2040, 2040, g);
      chk_bit(1'b1, cpu_clock_running);
      tick_gap(g);
      chk_range(16, 16, g);
   endtask

   task automatic s_clock_out();
      logic [7:0] v;
      logic       a;
      int         g;
      sfr_rd(TRIM_ADDR, v);
      sfr_wr(TRIM_ADDR, v | 8'h40);
      sfr_rd(TRIM_ADDR, v);
      chk_byte(8'h7f, v);
      tick_gap(g);
      repeat (4) @(negedge sys_clk);
      chk_bit(1'b0, xo_oe_n);
      a = xo_out;
      tick_gap(g);
      repeat (4) @(negedge sys_clk);
      chk_bit(~a, xo_out);
      tick_gap(g);
      repeat (4) @(negedge sys_clk);
      chk_bit(a, xo_out);
   endtask

   task automatic s_wakeup();
      int   c;
      logic a;
      @(negedge sys_clk);
      wakeup_request = 1'b1;
      @(negedge sys_clk);
      wakeup_request = 1'b0;
      repeat (3) @(negedge sys_clk);
      chk_bit(1'b0, cpu_clock_running);
      a = xo_out;
      repeat (50) @(negedge sys_clk);
      // With the CPU clock held, the clock output must not move.
      chk_bit(a, xo_out);
      chk_range(50, 1000, since_tick);
      wait_run(c);
      // The hold is timed from the request, so the cycles already waited count.
      chk_range(223 * 4 + FIXED, 225 * 4 + FIXED + 8, c + 54);
   endtask

   // Watchdog source at 400 kHz is one tick per 250 cycles; divide value 2 gives 4 ticks.
   task automatic s_watchdog();
      int g;
      osc_source_select = SRC_WDT;
      tick_gap(g);
      tick_gap(g);
      chk_range(1000, 1000, g);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      s_hold(SRC_RC, 1'b1, 224, 6 + 32);
      s_reset_values();
      s_register_access();
      s_hold(SRC_RC, 1'b0, 224, 6 + 63);
      s_hold(SRC_EXT, 1'b0, 224, 4);
      s_divider();
      s_clock_out();
      s_wakeup();
      s_watchdog();
      s_hold(SRC_XTAL, 1'b0, 992, 4);
      repeat (8) @(negedge sys_clk);
      chk_bit(1'b1, xo_oe_n);
      close_out();
   end
endmodule

/* File: hdl/clock_control_pkg.sv */
// Shared constants, types and helpers for the CPU clock control block.
package clock_control_pkg;

   // Special function register addresses.
   localparam logic [7:0] TRIM_ADDR      = 8'h96;
   localparam logic [7:0] AUX_ONE_ADDR   = 8'ha2;
   localparam logic [7:0] DIVIDER_ADDR   = 8'h95;

   // Field positions.
   localparam int         CLOCK_OUT_EN_BIT = 6;
   localparam int         TRIM_MSB       = 5;
   localparam int         LOW_POWER_BIT  = 7;

   // Reset values.
   localparam logic [5:0] TRIM_FACTORY   = 6'h20;
   localparam logic [7:0] DIVIDER_RESET  = 8'h00;

   // Timing.
   localparam int         SYS_CLK_KHZ    = 100000;
   localparam int         WDT_OSC_KHZ    = 400;
   localparam logic [7:0] WDT_PERIOD     = 8'(SYS_CLK_KHZ / WDT_OSC_KHZ);
   localparam logic [7:0] RC_BASE_PERIOD = 8'h06;
   localparam logic [9:0] HOLD_XTAL_TICKS = 10'd992;
   localparam logic [9:0] HOLD_RC_TICKS  = 10'd224;
   localparam int         HOLD_FIXED_US  = 60;
   localparam int         HOLD_FIXED_CYCLES = (HOLD_FIXED_US * SYS_CLK_KHZ + 999) / 1000;

   typedef enum logic [1:0] {SRC_RC, SRC_WDT, SRC_XTAL, SRC_EXT} osc_source_type;
   typedef enum logic [1:0] {HOLD_OSC, HOLD_FIXED, CLOCK_RUN} wake_state_type;

   function automatic logic sfr_hit(input logic strobe, input logic [7:0] addr,
                                    input logic [7:0] target);
      return strobe && (addr == target);
   endfunction

endpackage

/* File: hdl/cpu_clock_control.sv */
// CPU clock control: oscillator sources, trim register, wakeup hold and divider.
`timescale 1ns/1ps
// Notes on behaviour
// - Every reset clears low power select bit.
// - Trim register: reserved, clock enable, six trim bits.
// - Only power-on reset loads trim, clears enable.
// - Enabled clock output is half CPU clock.
// - Larger trim value lowers RC oscillator frequency.
// - Watchdog oscillator near 400KHz is selectable.
// - External clock comes from crystal input pin.
// - Wakeup timer holds CPU clock until stable.
// - Crystal oscillator holds 992 ticks plus 60us; external clock holds 224.
// - RC and watchdog hold 224 ticks plus 60us.
// - CPU clock is oscillator over twice N; N of zero passes the oscillator undivided.
// - Divider value may change at any time.
module cpu_clock_control #(
   parameter int HOLD_FIXED_COUNT = clock_control_pkg::HOLD_FIXED_CYCLES
) (
   // Clock and resets.
   input  wire logic                              sys_clk,
   input  wire logic                              rst_n,
   input  wire logic                              por_n,
   // Special function register port.
   input  wire logic [7:0]                        sfr_addr,
   input  wire logic                              sfr_write,
   input  wire logic                              sfr_read,
   input  wire logic [7:0]                        sfr_wdata,
   output      logic [7:0]                        sfr_rdata,
   // Configuration and wakeup.
   input  wire clock_control_pkg::osc_source_type osc_source_select,
   input  wire logic                              wakeup_request,
   // Pins.
   input  wire logic                              crystal_input_pin,
   output      logic                              crystal_output_pin_out,
   output      logic                              crystal_output_pin_oe_n,
   // CPU clock.
   output      logic                              cpu_clock_tick,
   output      logic                              cpu_clock_running,
   output      logic                              low_power_clock_select
);
   import clock_control_pkg::*;

   osc_clock_if clk_if ();

   ////////////////////////////////////////////////////////////////////////////
   // Registers reached from software.
   logic       clock_output_enable_reg;
   logic       clock_output_enable_next;
   logic [5:0] trim_reg;
   logic [5:0] trim_next;
   logic       low_power_reg;
   logic       low_power_next;
   logic [7:0] divider_value_reg;
   logic [7:0] divider_value_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic       trim_wr;
   logic       aux_wr;
   logic       div_wr;

   always_comb begin
      trim_wr = sfr_hit(sfr_write, sfr_addr, TRIM_ADDR);
      aux_wr  = sfr_hit(sfr_write, sfr_addr, AUX_ONE_ADDR);
      div_wr  = sfr_hit(sfr_write, sfr_addr, DIVIDER_ADDR);
      clock_output_enable_next = clock_output_enable_reg;
      trim_next          = trim_reg;
      low_power_next     = low_power_reg;
      divider_value_next = divider_value_reg;
      rdata_next         = rdata_reg;
      if (trim_wr) begin
         // The reserved top bit is dropped.
         clock_output_enable_next = sfr_wdata[CLOCK_OUT_EN_BIT];
         trim_next                = sfr_wdata[TRIM_MSB:0];
      end
      if (aux_wr) begin
         low_power_next = sfr_wdata[LOW_POWER_BIT];
      end
      if (div_wr) begin
         divider_value_next = sfr_wdata;
      end
      if (sfr_hit(sfr_read, sfr_addr, TRIM_ADDR)) begin
         rdata_next = {1'b0, clock_output_enable_reg, trim_reg};
      end else if (sfr_hit(sfr_read, sfr_addr, AUX_ONE_ADDR)) begin
         rdata_next = {low_power_reg, 7'h00};
      end else if (sfr_hit(sfr_read, sfr_addr, DIVIDER_ADDR)) begin
         rdata_next = divider_value_reg;
      end else if (sfr_read) begin
         rdata_next = 8'h00;
      end
   end

   // Trim and clock output enable survive every reset but power-on.
   always_ff @(posedge sys_clk or negedge por_n) begin
      if (!por_n) begin
         clock_output_enable_reg <= 1'b0;
         trim_reg                <= TRIM_FACTORY;
      end else begin
         clock_output_enable_reg <= clock_output_enable_next;
         trim_reg                <= trim_next;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         low_power_reg     <= 1'b0;
         divider_value_reg <= DIVIDER_RESET;
         rdata_reg         <= 8'h00;
      end else begin
         low_power_reg     <= low_power_next;
         divider_value_reg <= divider_value_next;
         rdata_reg         <= rdata_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Oscillator sources.
   logic [7:0] rc_count_reg;
   logic [7:0] rc_count_next;
   logic [7:0] wdt_count_reg;
   logic [7:0] wdt_count_next;
   logic       xtal_prev_reg;
   logic       osc_tick_reg;
   logic       osc_tick_next;
   logic       rc_tick;
   logic       wdt_tick;

   always_comb begin
      // The trim value lengthens the period, so a larger value is slower.
      rc_tick       = (rc_count_reg >= RC_BASE_PERIOD + {2'b00, trim_reg} - 8'h01);
      rc_count_next = rc_tick ? 8'h00 : rc_count_reg + 8'h01;
      wdt_tick       = (wdt_count_reg == WDT_PERIOD - 8'h01);
      wdt_count_next = wdt_tick ? 8'h00 : wdt_count_reg + 8'h01;
      case (osc_source_select)
         SRC_RC:  osc_tick_next = rc_tick;
         SRC_WDT: osc_tick_next = wdt_tick;
         default: osc_tick_next = crystal_input_pin && !xtal_prev_reg;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rc_count_reg  <= 8'h00;
         wdt_count_reg <= 8'h00;
         xtal_prev_reg <= 1'b0;
         osc_tick_reg  <= 1'b0;
      end else begin
         rc_count_reg  <= rc_count_next;
         wdt_count_reg <= wdt_count_next;
         xtal_prev_reg <= crystal_input_pin;
         osc_tick_reg  <= osc_tick_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Wakeup hold.
   wake_state_type state_reg;
   wake_state_type state_next;
   logic [9:0]     osc_count_reg;
   logic [9:0]     osc_count_next;
   logic [15:0]    fixed_count_reg;
   logic [15:0]    fixed_count_next;
   logic [9:0]     hold_target;

   always_comb begin
      hold_target = (osc_source_select == SRC_XTAL) ? HOLD_XTAL_TICKS
                                                    : HOLD_RC_TICKS;
      state_next       = state_reg;
      osc_count_next   = osc_count_reg;
      fixed_count_next = fixed_count_reg;
      case (state_reg)
         HOLD_OSC: begin
            if (osc_tick_reg) begin
               if (osc_count_reg == hold_target - 10'd1) begin
                  state_next     = HOLD_FIXED;
                  osc_count_next = 10'd0;
               end else begin
                  osc_count_next = osc_count_reg + 10'd1;
               end
            end
         end
         HOLD_FIXED: begin
            if (fixed_count_reg == 16'(HOLD_FIXED_COUNT - 1)) begin
               state_next       = CLOCK_RUN;
               fixed_count_next = 16'h0000;
            end else begin
               fixed_count_next = fixed_count_reg + 16'h0001;
            end
         end
         default: begin
            if (wakeup_request) begin
               state_next = HOLD_OSC;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg       <= HOLD_OSC;
         osc_count_reg   <= 10'd0;
         fixed_count_reg <= 16'h0000;
      end else begin
         state_reg       <= state_next;
         osc_count_reg   <= osc_count_next;
         fixed_count_reg <= fixed_count_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Divider and clock output.
   logic clock_out_reg;
   logic clock_out_next;
   logic drive_reg;
   logic drive_next;

   assign clk_if.osc_tick     = osc_tick_reg;
   assign clk_if.hold         = (state_reg != CLOCK_RUN);
   assign clk_if.divide_value = divider_value_reg;

   cpu_clock_divider divider_inst (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .clk_if  (clk_if.divider)
   );

   always_comb begin
      // The pin is free only when no crystal oscillator owns it.
      drive_next  = clock_output_enable_reg && (osc_source_select != SRC_XTAL);
      clock_out_next = clock_out_reg;
      if (!drive_next) begin
         clock_out_next = 1'b0;
      end else if (clk_if.cpu_tick) begin
         clock_out_next = !clock_out_reg;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         clock_out_reg <= 1'b0;
         drive_reg     <= 1'b0;
      end else begin
         clock_out_reg <= clock_out_next;
         drive_reg     <= drive_next;
      end
   end

   assign crystal_output_pin_out  = clock_out_reg;
   assign crystal_output_pin_oe_n = !drive_reg;
   assign cpu_clock_tick          = clk_if.cpu_tick;
   assign cpu_clock_running       = (state_reg == CLOCK_RUN);
   assign low_power_clock_select  = low_power_reg;
   assign sfr_rdata               = rdata_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   // Once the hold is entered the clock stops and no tick comes in the cycle after.
   sequence hold_entered_s;
      !cpu_clock_running ##1 !cpu_clock_tick;
   endsequence

   trim_write_a: assert property (trim_wr |=> {clock_output_enable_reg, trim_reg}
      == $past(sfr_wdata[6:0])) else $error("Trim write not stored.");
   trim_reserved_a: assert property (sfr_hit(sfr_read, sfr_addr, TRIM_ADDR) |=> !sfr_rdata[7])
      else $error("Reserved trim bit read as one.");
   trim_keep_a: assert property (!trim_wr && por_n |=> $stable(trim_reg))
      else $error("Trim changed without a write.");
   low_power_set_a: assert property ($rose(low_power_reg) |-> $past(aux_wr))
      else $error("Low power bit rose without a write.");
   clock_out_half_a: assert property (drive_reg && drive_next && clk_if.cpu_tick
      |=> clock_out_reg != $past(clock_out_reg))
      else $error("Clock output missed a toggle.");
   wdt_period_a: assert property (wdt_tick |=> !wdt_tick [*8])
      else $error("Watchdog oscillator period too short.");
   fixed_wait_a: assert property ($rose(cpu_clock_running) |-> $past(state_reg == HOLD_FIXED))
      else $error("CPU clock released before fixed wait.");
   hold_entry_a: assert property (cpu_clock_running && wakeup_request |=> hold_entered_s)
      else $error("Wakeup did not hold clock.");
   hold_count_a: assert property (state_reg == HOLD_OSC && state_next == HOLD_FIXED
      |-> osc_tick_reg && osc_count_reg == ((osc_source_select == SRC_XTAL)
      ? HOLD_XTAL_TICKS - 10'd1 : HOLD_RC_TICKS - 10'd1))
      else $error("Oscillator hold count wrong.");
   divider_load_a: assert property (div_wr |=> divider_value_reg == $past(sfr_wdata))
      else $error("Divider value not stored.");
endmodule

/* File: hdl/cpu_clock_divider.sv */
// Integer divider that makes the CPU clock tick from the oscillator tick.
`timescale 1ns/1ps
module cpu_clock_divider (
   // Clock and reset.
   input wire logic        sys_clk,
   input wire logic        rst_n,
   // Tick and divide value.
   osc_clock_if.divider    clk_if
);
   import clock_control_pkg::*;

   logic [7:0] active_reg;
   logic [7:0] active_next;
   logic [8:0] count_reg;
   logic [8:0] count_next;
   logic       tick_reg;
   logic       tick_next;
   logic [8:0] period;

   always_comb begin
      period      = (active_reg == 8'h00) ? 9'h001 : {active_reg, 1'b0};
      active_next = active_reg;
      count_next  = count_reg;
      tick_next   = 1'b0;
      if (clk_if.hold) begin
         count_next  = 9'h000;
         active_next = clk_if.divide_value;
      end else if (clk_if.osc_tick) begin
         if (count_reg + 9'h001 >= period) begin
            tick_next   = 1'b1;
            count_next  = 9'h000;
            // A new ratio takes effect only at a period boundary or while the clock is held.
            active_next = clk_if.divide_value;
         end else begin
            count_next = count_reg + 9'h001;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         active_reg <= DIVIDER_RESET;
         count_reg  <= 9'h000;
         tick_reg   <= 1'b0;
      end else begin
         active_reg <= active_next;
         count_reg  <= count_next;
         tick_reg   <= tick_next;
      end
   end

   assign clk_if.cpu_tick = tick_reg;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   undivided_pass_a: assert property ((active_reg == 8'h00) && clk_if.osc_tick && !clk_if.hold
      |=> tick_reg) else $error("Undivided clock missed a tick.");
   ratio_boundary_a: assert property ($changed(active_reg) |-> $past(tick_next || clk_if.hold))
      else $error("Divide ratio changed inside a period.");
   held_quiet_a: assert property (clk_if.hold |=> !tick_reg)
      else $error("CPU clock ticked during hold.");
endmodule

/* File: hdl/osc_clock_if.sv */
// Oscillator tick, hold and divide value passed to the CPU clock divider.
`timescale 1ns/1ps
interface osc_clock_if;
   logic       osc_tick;
   logic       hold;
   logic [7:0] divide_value;
   logic       cpu_tick;
   modport control (output osc_tick, output hold, output divide_value, input cpu_tick);
   modport divider (input osc_tick, input hold, input divide_value, output cpu_tick);
endinterface
